// file: src/i2c_status_interrupt_logic.sv
// Purpose: Status register, event flag and bus engine of a two-wire serial interface
// Assumes: Register port is the core's special-function access; link logic on link_clk
// Notes: Own address, control bits and data access arrive as plain ports
// Behaviour
// - The interrupt request rises only with the engine enabled, its own enable and the global enable all set.
// - As slave with acknowledge enabled, an address equal to the own address sets the event flag.
// - As slave with acknowledge enabled, the general call address sets the event flag.
// - As master, each complete byte sets the event flag, even after lost arbitration.
// - As selected slave, each complete byte sent or received sets the event flag.
// - As selected slave, a STOP on the bus sets the event flag.
// - The engine is a selected slave only if the address of the current transfer matched its own or was the general call address.
// - The event flag is set whether or not interrupts are enabled, so it can be polled.
// - Writes to the status register change only the event flag bit.
// - The status register sits at DDh, resets to 00h, and holds the eight documented flags.
// - The stop bit reads 1 once a STOP is seen on the bus, as master or slave.
// - The event flag stays set until software clears it.
// - With acknowledge enabled the engine pulls data low in the acknowledge slot of accepted bytes.
// - With the interface disabled both lines are released and the engine stays idle.
// - After a byte, unless arbitration was lost, the clock is held low until software writes (transmit) or reads (receive) data, or as master requests a STOP.
`timescale 1ns/1ns
`default_nettype none
module i2c_status_interrupt_logic (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic interface_enable,
  input wire logic ack_enable,
  input wire logic [6:0] own_address_reg,
  input wire logic serial_irq_enable,
  input wire logic global_irq_enable,
  input wire logic start_request,
  input wire logic stop_request,
  input wire logic [7:0] tx_byte,
  input wire logic data_write,
  input wire logic data_read,
  output logic [7:0] rx_byte,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ==========================================
  // Core-clock side
  logic event_flag, next_event_flag;
  logic [7:0] rdata_next;
  logic [7:0] next_rx_byte;
  logic [7:0] tx_data, next_tx_data;
  logic st_tgl, next_st_tgl, sp_tgl, next_sp_tgl, rel_tgl, next_rel_tgl;
  logic ev_seen, next_ev_seen;
  logic ev_tgl_s, ev_pulse, status_wr;
  logic [7:0] status_s;
  logic [7:0] status_word, next_status_word;
  logic ev_tgl, next_ev_tgl;
  logic [7:0] rx_hold, next_rx_hold;

  level_sync #(.W(8)) status_sync (.clk(clk_sys), .rst(sys_rst), .d(status_word), .q(status_s));
  level_sync #(.W(1)) event_sync (.clk(clk_sys), .rst(sys_rst), .d(ev_tgl), .q(ev_tgl_s));

  assign ev_pulse = ev_tgl_s != ev_seen;
  assign status_wr = sfr_wr && (sfr_addr == i2c_status_pkg::STATUS_ADDR);
  assign irq = event_flag && serial_irq_enable && global_irq_enable && interface_enable;

  always_comb begin
    next_ev_seen = ev_tgl_s;
    // Set wins over a clearing write in the same cycle
    next_event_flag = event_flag;
    if (status_wr) begin
      next_event_flag = sfr_wdata[i2c_status_pkg::EVENT_BIT];
    end
    if (ev_pulse) begin
      next_event_flag = 1'b1;
    end
    next_rx_byte = ev_pulse ? rx_hold : rx_byte;
    next_tx_data = data_write ? tx_byte : tx_data;
    next_st_tgl = st_tgl ^ start_request;
    next_sp_tgl = sp_tgl ^ stop_request;
    // Transmit releases the wait on a data write, receive on a data read
    next_rel_tgl = rel_tgl ^ (status_s[i2c_status_pkg::TX_BIT] ? data_write : data_read);
    rdata_next = 8'h00;
    if (sfr_rd && sfr_addr == i2c_status_pkg::STATUS_ADDR) begin
      rdata_next = status_s;
      rdata_next[i2c_status_pkg::EVENT_BIT] = event_flag;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      event_flag <= 1'b0;
      ev_seen <= 1'b0;
      rx_byte <= 8'h00;
      tx_data <= 8'h00;
      st_tgl <= 1'b0;
      sp_tgl <= 1'b0;
      rel_tgl <= 1'b0;
      sfr_rdata <= i2c_status_pkg::STATUS_RESET;
    end else begin
      event_flag <= next_event_flag;
      ev_seen <= next_ev_seen;
      rx_byte <= next_rx_byte;
      tx_data <= next_tx_data;
      st_tgl <= next_st_tgl;
      sp_tgl <= next_sp_tgl;
      rel_tgl <= next_rel_tgl;
      sfr_rdata <= rdata_next;
    end
  end

  // ==========================================
  // Link side
  logic scl_s, sda_s, ien_s, aen_s, st_s, sp_s, rel_s;
  logic [6:0] own_s;
  logic start_det, stop_det, scl_rise, scl_fall, rel_pulse, txing;
  i2c_status_pkg::link_state_t lstate, next_lstate;
  logic [6:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, sampled;
  logic is_master, next_is_master, selected, next_selected, slave_tx, next_slave_tx;
  logic m_tx, next_m_tx, addr_phase, next_addr_phase, hold, next_hold, ev_pend, next_ev_pend;
  logic lost, next_lost, busy, next_busy, stop_seen, next_stop_seen, gc, next_gc;
  logic noack, next_noack, next_sda_oe, next_scl_oe;
  logic pend_start, next_pend_start, pend_stop, next_pend_stop;
  logic st_prev, sp_prev, rel_prev;

  level_sync #(.W(2)) pin_sync (.clk(link_clk), .rst(sys_rst), .d({scl_in, sda_in}), .q({scl_s, sda_s}));
  level_sync #(.W(12)) cfg_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .d({interface_enable, ack_enable, own_address_reg, st_tgl, sp_tgl, rel_tgl}),
    .q({ien_s, aen_s, own_s, st_s, sp_s, rel_s})
  );
  bus_condition cond (
    .clk(link_clk),
    .rst(sys_rst),
    .scl(scl_s),
    .sda(sda_s),
    .start_det(start_det),
    .stop_det(stop_det),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall)
  );

  // Open-drain: lines are only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign rel_pulse = rel_s != rel_prev;
  assign txing = addr_phase || m_tx;

  // Level to put on data for the coming master bit; 1 means pull low
  function automatic logic bit_drive(input logic [3:0] n, input logic [7:0] sh, input logic tx,
                                     input logic lost_v, input logic aen);
    if (n < i2c_status_pkg::ACK_SLOT) begin
      bit_drive = tx && !lost_v && !sh[7];
    end else begin
      bit_drive = !tx && aen;
    end
  endfunction : bit_drive

  always_comb begin
    next_lstate = lstate;
    next_cnt = cnt;
    next_bitn = bitn;
    next_shreg = shreg;
    next_is_master = is_master;
    next_selected = selected;
    next_slave_tx = slave_tx;
    next_m_tx = m_tx;
    next_addr_phase = addr_phase;
    next_hold = hold;
    next_ev_pend = ev_pend;
    next_lost = lost;
    next_busy = busy;
    next_stop_seen = stop_seen;
    next_gc = gc;
    next_noack = noack;
    next_sda_oe = sda_oe;
    next_scl_oe = scl_oe;
    next_ev_tgl = ev_tgl;
    next_rx_hold = rx_hold;
    next_pend_start = pend_start || (st_s != st_prev);
    next_pend_stop = pend_stop || (sp_s != sp_prev);
    sampled = {shreg[6:0], sda_s};
    if (start_det) begin
      next_busy = 1'b1;
      next_stop_seen = 1'b0;
      next_gc = 1'b0;
      next_noack = 1'b0;
      next_selected = 1'b0;
      if (!is_master) begin
        next_addr_phase = 1'b1;
        next_bitn = 4'h0;
        next_slave_tx = 1'b0;
      end
    end else if (stop_det) begin
      next_busy = 1'b0;
      next_stop_seen = 1'b1;
      next_gc = 1'b0;
      next_selected = 1'b0;
      next_addr_phase = 1'b0;
      if (selected && !is_master) begin
        next_ev_tgl = !ev_tgl;
        next_sda_oe = 1'b0;
      end
    end else if (!is_master) begin
      if (hold) begin
        if (rel_pulse) begin
          next_hold = 1'b0;
          next_scl_oe = 1'b0;
          // A master that refused the last byte gets a free data line for its STOP
          if (slave_tx && selected && !noack) begin
            next_shreg = tx_data;
            next_sda_oe = !tx_data[7];
          end
        end
      end else if (scl_rise && (addr_phase || selected)) begin
        if (bitn < i2c_status_pkg::ACK_SLOT) begin
          next_shreg = sampled;
          next_bitn = bitn + 4'h1;
        end else if (bitn == i2c_status_pkg::ACK_SLOT) begin
          if (slave_tx) begin
            next_noack = sda_s;
          end
          next_bitn = i2c_status_pkg::ACK_DONE;
        end
      end else if (scl_fall && (addr_phase || selected)) begin
        if (bitn == i2c_status_pkg::ACK_SLOT) begin
          next_addr_phase = 1'b0;
          if (addr_phase) begin
            if (aen_s && shreg[7:1] == own_s) begin
              next_selected = 1'b1;
              next_slave_tx = shreg[0];
              next_ev_pend = 1'b1;
              next_sda_oe = 1'b1;
            end else if (aen_s && shreg == i2c_status_pkg::GENERAL_CALL_ADDR) begin
              next_selected = 1'b1;
              next_gc = 1'b1;
              next_ev_pend = 1'b1;
              next_sda_oe = 1'b1;
            end
          end else begin
            next_ev_pend = 1'b1;
            next_sda_oe = !slave_tx && aen_s;
            if (!slave_tx) begin
              next_rx_hold = shreg;
            end
          end
        end else if (bitn == i2c_status_pkg::ACK_DONE) begin
          next_sda_oe = 1'b0;
          next_bitn = 4'h0;
          if (ev_pend) begin
            next_ev_pend = 1'b0;
            next_ev_tgl = !ev_tgl;
            next_hold = 1'b1;
            next_scl_oe = 1'b1;
          end
        end else if (slave_tx && selected && !noack) begin
          next_sda_oe = !shreg[7];
        end
      end
    end
    case (lstate)
      i2c_status_pkg::L_IDLE: begin
        if (pend_start && !busy && !hold) begin
          next_pend_start = 1'b0;
          next_is_master = 1'b1;
          next_sda_oe = 1'b1;
          next_cnt = i2c_status_pkg::SCL_HALF;
          next_lost = 1'b0;
          next_shreg = tx_data;
          next_addr_phase = 1'b1;
          next_m_tx = 1'b1;
          next_bitn = 4'h0;
          next_lstate = i2c_status_pkg::L_START;
        end
      end
      i2c_status_pkg::L_START: begin
        next_cnt = cnt - 7'h01;
        if (cnt == 7'h00) begin
          next_scl_oe = 1'b1;
          next_cnt = i2c_status_pkg::SCL_HALF;
          next_sda_oe = bit_drive(4'h0, shreg, 1'b1, lost, aen_s);
          next_lstate = i2c_status_pkg::L_LOW;
        end
      end
      i2c_status_pkg::L_LOW: begin
        next_cnt = cnt - 7'h01;
        if (cnt == 7'h00) begin
          next_scl_oe = 1'b0;
          next_cnt = i2c_status_pkg::SCL_HALF;
          next_lstate = i2c_status_pkg::L_HIGH;
        end
      end
      i2c_status_pkg::L_HIGH: begin
        // Count only while the line is really high, so a slower clock stretches the bit
        if (scl_s && cnt != 7'h00) begin
          next_cnt = cnt - 7'h01;
        end else if (scl_s) begin
          next_scl_oe = 1'b1;
          next_cnt = i2c_status_pkg::SCL_HALF;
          if (bitn < i2c_status_pkg::ACK_SLOT) begin
            next_lost = lost || (txing && shreg[7] && !sda_s);
            next_shreg = sampled;
            next_bitn = bitn + 4'h1;
            next_sda_oe = bit_drive(bitn + 4'h1, sampled, txing, next_lost, aen_s);
            next_lstate = i2c_status_pkg::L_LOW;
          end else begin
            if (txing) begin
              next_noack = sda_s;
            end
            if (addr_phase) begin
              next_m_tx = !shreg[0];
            end
            next_addr_phase = 1'b0;
            next_rx_hold = shreg;
            next_sda_oe = 1'b0;
            next_ev_tgl = !ev_tgl;
            next_lstate = i2c_status_pkg::L_HOLD;
            if (lost) begin
              // A beaten master finishes the byte, then leaves the clock to the winner
              next_is_master = 1'b0;
              next_scl_oe = 1'b0;
              next_lstate = i2c_status_pkg::L_IDLE;
            end
          end
        end
      end
      i2c_status_pkg::L_HOLD: begin
        if (pend_stop) begin
          next_pend_stop = 1'b0;
          next_sda_oe = 1'b1;
          next_cnt = i2c_status_pkg::SCL_HALF;
          next_lstate = i2c_status_pkg::L_STOP_LOW;
        end else if (rel_pulse) begin
          next_bitn = 4'h0;
          next_shreg = m_tx ? tx_data : shreg;
          next_sda_oe = bit_drive(4'h0, tx_data, m_tx, lost, aen_s);
          next_cnt = i2c_status_pkg::SCL_HALF;
          next_lstate = i2c_status_pkg::L_LOW;
        end
      end
      i2c_status_pkg::L_STOP_LOW: begin
        next_cnt = cnt - 7'h01;
        if (cnt == 7'h00) begin
          next_scl_oe = 1'b0;
          next_cnt = i2c_status_pkg::SCL_HALF;
          next_lstate = i2c_status_pkg::L_STOP_HIGH;
        end
      end
      i2c_status_pkg::L_STOP_HIGH: begin
        if (scl_s && cnt != 7'h00) begin
          next_cnt = cnt - 7'h01;
        end else if (scl_s) begin
          next_sda_oe = 1'b0;
          next_is_master = 1'b0;
          next_lstate = i2c_status_pkg::L_IDLE;
        end
      end
      default: next_lstate = i2c_status_pkg::L_IDLE;
    endcase
    if (!ien_s) begin
      next_lstate = i2c_status_pkg::L_IDLE;
      next_is_master = 1'b0;
      next_selected = 1'b0;
      next_addr_phase = 1'b0;
      next_hold = 1'b0;
      next_ev_pend = 1'b0;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_pend_start = 1'b0;
      next_pend_stop = 1'b0;
    end
    next_status_word = 8'h00;
    next_status_word[i2c_status_pkg::GC_BIT] = next_gc;
    next_status_word[i2c_status_pkg::STOP_BIT] = next_stop_seen;
    next_status_word[i2c_status_pkg::TX_BIT] = next_is_master ? next_m_tx : next_slave_tx;
    next_status_word[i2c_status_pkg::BUSY_BIT] = next_busy;
    next_status_word[i2c_status_pkg::LOST_BIT] = next_lost;
    next_status_word[i2c_status_pkg::NOACK_BIT] = next_noack;
    next_status_word[i2c_status_pkg::SLAVE_BIT] = !next_is_master && ien_s;
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lstate <= i2c_status_pkg::L_IDLE;
      cnt <= 7'h00;
      bitn <= 4'h0;
      shreg <= 8'h00;
      {is_master, selected, slave_tx, m_tx, addr_phase, hold, ev_pend} <= 7'h00;
      {lost, busy, stop_seen, gc, noack, sda_oe, scl_oe, ev_tgl} <= 8'h00;
      {pend_start, pend_stop, st_prev, sp_prev, rel_prev} <= 5'h00;
      rx_hold <= 8'h00;
      status_word <= i2c_status_pkg::STATUS_RESET;
    end else begin
      lstate <= next_lstate;
      cnt <= next_cnt;
      bitn <= next_bitn;
      shreg <= next_shreg;
      {is_master, selected, slave_tx, m_tx, addr_phase, hold, ev_pend} <=
        {next_is_master, next_selected, next_slave_tx, next_m_tx, next_addr_phase, next_hold, next_ev_pend};
      {lost, busy, stop_seen, gc, noack, sda_oe, scl_oe, ev_tgl} <=
        {next_lost, next_busy, next_stop_seen, next_gc, next_noack, next_sda_oe, next_scl_oe, next_ev_tgl};
      {pend_start, pend_stop, st_prev, sp_prev, rel_prev} <= {next_pend_start, next_pend_stop, st_s, sp_s, rel_s};
      rx_hold <= next_rx_hold;
      status_word <= next_status_word;
    end
  end

  // ==========================================
  // Checks
  sequence slave_fall_s;
    !is_master && ien_s && !hold && !start_det && !stop_det && scl_fall;
  endsequence
  sequence master_byte_end_s;
    lstate == i2c_status_pkg::L_HIGH && scl_s && cnt == 7'h00 && bitn == i2c_status_pkg::ACK_SLOT && ien_s;
  endsequence

  irq_gating_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq |-> event_flag && serial_irq_enable && global_irq_enable && interface_enable)
    else $error("irq without flag and enables");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ev_pulse |=> event_flag)
    else $error("event did not set flag");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    event_flag && !status_wr |=> event_flag)
    else $error("flag cleared without a write");
  irq_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    status_wr && !sfr_wdata[i2c_status_pkg::EVENT_BIT] && !ev_pulse |=> !event_flag && !irq)
    else $error("clearing write did not drop flag");
  status_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sfr_rd && sfr_addr == i2c_status_pkg::STATUS_ADDR |=>
      sfr_rdata[7:6] == $past(status_s[7:6]) && sfr_rdata[4:0] == $past(status_s[4:0]))
    else $error("status read mismatch");
  idle_release_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !ien_s |=> !scl_oe && !sda_oe)
    else $error("lines driven while disabled");
  stop_seen_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    stop_det && ien_s |=> stop_seen && !busy)
    else $error("stop not recorded");
  addr_match_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    slave_fall_s and (addr_phase && bitn == i2c_status_pkg::ACK_SLOT && aen_s && shreg[7:1] == own_s)
      |=> selected && sda_oe && ev_pend)
    else $error("own address not acknowledged");
  general_call_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    slave_fall_s and (addr_phase && bitn == i2c_status_pkg::ACK_SLOT && aen_s &&
      shreg == i2c_status_pkg::GENERAL_CALL_ADDR) |=> gc && ev_pend)
    else $error("general call missed");
  slave_byte_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    slave_fall_s and (bitn == i2c_status_pkg::ACK_DONE && ev_pend) |=> ev_tgl != $past(ev_tgl) && hold && scl_oe)
    else $error("slave byte event missed");
  slave_stop_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !is_master && ien_s && selected && stop_det |=> ev_tgl != $past(ev_tgl) && !selected)
    else $error("selected stop event missed");
  master_byte_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    master_byte_end_s |=> ev_tgl != $past(ev_tgl))
    else $error("master byte event missed");
  select_clear_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    start_det && ien_s |=> !selected)
    else $error("selection survived start");
endmodule : i2c_status_interrupt_logic
`default_nettype wire

// file: src/i2c_status_pkg.sv
// Purpose: Shared constants and types of the two-wire status and event-flag logic
// Assumes: Core clock 10 MHz, link-side clock 12.5 MHz (80 ns)
// Notes: Status register layout, reset value and link timing counts
package i2c_status_pkg;

  // ==========================================
  // Register map
  localparam logic [7:0] STATUS_ADDR = 8'hdd;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int GC_BIT = 7;
  localparam int STOP_BIT = 6;
  localparam int EVENT_BIT = 5;
  localparam int TX_BIT = 4;
  localparam int BUSY_BIT = 3;
  localparam int LOST_BIT = 2;
  localparam int NOACK_BIT = 1;
  localparam int SLAVE_BIT = 0;

  // ==========================================
  // Bus constants
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  // ==========================================
  // Timing
  localparam int LINK_CLK_NS = 80;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam logic [6:0] SCL_HALF = 7'(SCL_HALF_CYC);

  typedef enum {
    L_IDLE,
    L_START,
    L_LOW,
    L_HIGH,
    L_HOLD,
    L_STOP_LOW,
    L_STOP_HIGH
  } link_state_t;

endpackage : i2c_status_pkg

// file: src/level_sync.sv
// Purpose: Two-flop synchroniser for levels and toggles
// Assumes: Multi-bit inputs are static or change one bit at a time
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : level_sync
`default_nettype wire

// file: src/bus_condition.sv
// Purpose: START, STOP and clock-edge detection on synchronised bus lines
// Assumes: Inputs already pass two flops on this clock
// Notes: Outputs are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module bus_condition (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  output logic start_det,
  output logic stop_det,
  output logic scl_rise,
  output logic scl_fall
);
  logic scl_prev;
  logic sda_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_prev <= 1'b0;
      sda_prev <= 1'b0;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  // Data may only change with the clock low, so a change with it high marks a condition
  assign start_det = scl && scl_prev && sda_prev && !sda;
  assign stop_det = scl && scl_prev && !sda_prev && sda;
  assign scl_rise = scl && !scl_prev;
  assign scl_fall = !scl && scl_prev;
endmodule : bus_condition
`default_nettype wire

// file: bench/bus_master_model.sv
// Purpose: Two-wire bus master model
// Assumes: Pull-ups sit in the bench
// Notes: Stretch wait gives up after 300 us
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
  input wire logic scl,
  input wire logic sda,
  output var logic scl_low = 1'b0,
  output var logic sda_low = 1'b0,
  output var logic stuck = 1'b0
);
  // ==========
  // Bus cycles
  task automatic up();
    scl_low = 1'b0;
    for (int i = 0; i < 3000 && !scl; i++) #100;
    stuck |= !scl;
    #5000;
  endtask : up
  task automatic start();
    sda_low = 1'b1;
    #5000;
    scl_low = 1'b1;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #5000;
    up();
    sda_low = 1'b0;
    #5000;
  endtask : stop
  // Bit 0 is the acknowledge slot
  task automatic xfer(input logic [8:0] o, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !o[i];
      #2500;
      up();
      q[i] = sda;
      scl_low = 1'b1;
      #2500;
    end
  endtask : xfer
endmodule : bus_master_model
`default_nettype wire

// file: bench/tb_i2c_status_interrupt_logic.sv
// Purpose: Bench of the status and event-flag logic
// Assumes: Bench is core and pull-ups; model is the far master
// Notes: Master mode sends one address byte that nobody answers
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_status_interrupt_logic;
  logic clk_sys = 0, link_clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, data_write = 0, data_read = 0;
  logic interface_enable = 0, ack_enable = 0, serial_irq_enable = 0, global_irq_enable = 0;
  logic start_request = 0, stop_request = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, tx_byte = 0, sfr_rdata, rx_byte, r, d;
  logic [7:0] ad [6];
  logic [6:0] own_address_reg = 0;
  logic [8:0] got;
  logic [2:0] cf [6] = '{3'h7, 3'h6, 3'h7, 3'h4, 3'h2, 3'h7};
  logic irq, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda, stuck;
  wire logic scl_w = (scl_oe ? scl_out : 1'b1) & !m_scl;
  wire logic sda_w = (sda_oe ? sda_out : 1'b1) & !m_sda;
  int fail_count = 0, cmp_count = 0;
  always #50 clk_sys = !clk_sys;
  always #40 link_clk = !link_clk;
  i2c_status_interrupt_logic dut_u (.clk_sys, .sys_rst, .link_clk, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .interface_enable, .ack_enable, .own_address_reg, .serial_irq_enable, .global_irq_enable,
    .start_request, .stop_request, .tx_byte, .data_write, .data_read, .rx_byte, .irq,
    .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe);
  bus_master_model m_u (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda), .stuck);
  // ==========
  // Shared tasks
  task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s: expected %h seen %h", n, e, s);
    end
  endtask : check
  // Strobe bits: data_write, data_read, sfr_wr, sfr_rd
  task automatic strobe(input logic [3:0] s, input logic [7:0] a, input logic [7:0] w, output logic [7:0] q);
    @(posedge clk_sys);
    #5;
    {data_write, data_read, sfr_wr, sfr_rd} = s;
    sfr_addr = a;
    sfr_wdata = w;
    @(posedge clk_sys);
    #5;
    q = sfr_rdata;
    {data_write, data_read, sfr_wr, sfr_rd} = 4'h0;
  endtask : strobe
  // Polls until the flag shows; a flag that never comes is judged by the caller
  task automatic get(output logic [7:0] q);
    for (int i = 0; i < 40; i++) begin
      strobe(4'h1, 8'hdd, 8'h00, q);
      if (q[5]) break;
    end
    if (stuck) begin
      check("clock released", stuck, 1'b0);
      close_out();
    end
  endtask : get
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h0c870c87));
    own_address_reg = 7'($urandom_range(126, 2));
    ad = '{{own_address_reg, 1'b0}, {own_address_reg ^ 7'h01, 1'b0}, 8'h00, {own_address_reg, 1'b0},
      {own_address_reg, 1'b0}, {own_address_reg, 1'b1}};
    repeat (12) @(posedge clk_sys);
    #5;
    sys_rst = 1'b0;
    strobe(4'h1, 8'hdd, 8'h00, r);
    check("status reset", r, 8'h00);
    strobe(4'h1, 8'hde, 8'h00, r);
    check("unmapped", r, 8'h00);
    strobe(4'h2, 8'hdd, 8'hff, r);
    strobe(4'h1, 8'hdd, 8'h00, r);
    check("write mask", r, 8'h20);
    serial_irq_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      {interface_enable, global_irq_enable} = 2'(6'h39 >> (2 * k));
      strobe(4'h0, 8'hdd, 8'h00, r);
      check("irq", irq, k == 2);
    end
    strobe(4'h2, 8'hdd, 8'h00, r);
    strobe(4'h1, 8'hdd, 8'h00, r);
    check("flag clear", {irq, r}, 9'h001);
    serial_irq_enable = 1'b0;
    $display("test registers done");
    for (int c = 0; c < 6; c++) begin
      {interface_enable, ack_enable} = cf[c][2:1];
      d = 8'($urandom);
      tx_byte = d;
      strobe(4'h2, 8'hdd, 8'h00, r);
      m_u.start();
      m_u.xfer({ad[c], 1'b1}, got);
      check("address ack", got[0], !cf[c][0]);
      get(r);
      check("address event", r[5], cf[c][0]);
      check("irq masked", irq, 1'b0);
      if (cf[c][0]) begin
        check("role bits", {r[7], r[0]}, {c == 2, 1'b1});
        strobe({ad[c][0], !ad[c][0], 2'b10}, 8'hdd, 8'h00, r);
        m_u.xfer(ad[c][0] ? 9'h1ff : {d, 1'b1}, got);
        check("data ack", got[0], ad[c][0]);
        get(r);
        check("data byte", ad[c][0] ? got[8:1] : rx_byte, d);
        check("data event", r[5], 1'b1);
        strobe({ad[c][0], !ad[c][0], 2'b10}, 8'hdd, 8'h00, r);
      end
      m_u.stop();
      get(r);
      if (c != 2) check("stop event", r[5], cf[c][0]);
      if (cf[c][2]) check("stop seen", r[6], 1'b1);
      $display("test case %0d done", c);
    end
    tx_byte = {7'($urandom), 1'b0};
    strobe(4'ha, 8'hdd, 8'h00, r);
    start_request = 1'b1;
    @(posedge clk_sys);
    #5;
    start_request = 1'b0;
    repeat (1100) @(posedge clk_sys);
    get(r);
    check("master byte", {r[5], r[4], r[1], r[0]}, 4'he);
    stop_request = 1'b1;
    @(posedge clk_sys);
    #5;
    stop_request = 1'b0;
    repeat (150) @(posedge clk_sys);
    strobe(4'h1, 8'hdd, 8'h00, r);
    check("master stop", {r[6], r[3], r[0]}, 3'h5);
    $display("test master done");
    serial_irq_enable = 1'b1;
    strobe(4'h0, 8'hdd, 8'h00, r);
    check("irq level", irq, 1'b1);
    close_out();
  end
endmodule : tb_i2c_status_interrupt_logic
`default_nettype wire
